// >>> shared/iolfs_pkg.sv
// Package with setting codes, reset values and carrier types for the line function select
package iolfs_pkg;
  localparam int unsigned NUM_LINES = 9;
  localparam int unsigned SET_W = 3;
  localparam int unsigned IDX_W = 4;
  // Setting codes
  localparam logic [2:0] SET_DISABLED = 3'h0;
  localparam logic [2:0] SET_SPECIAL = 3'h1;
  localparam logic [2:0] SET_ANALOG = 3'h2;
  localparam logic [2:0] SET_DIG_IN = 3'h3;
  localparam logic [2:0] SET_OUT_LOW = 3'h4;
  localparam logic [2:0] SET_OUT_HIGH = 3'h5;
  localparam logic [2:0] SET_TXEN_LOW = 3'h6;
  localparam logic [2:0] SET_TXEN_HIGH = 3'h7;
  // Line indices with special roles
  localparam logic [3:0] LINE_INDICATOR = 4'h5;
  localparam logic [3:0] LINE_REQUEST = 4'h6;
  localparam logic [3:0] LINE_CLEAR = 4'h7;
  localparam logic [3:0] LINE_INPUT_ONLY = 4'h8;
  // Reset values
  localparam logic [2:0] RST_PLAIN = 3'h0;
  localparam logic [2:0] RST_INDICATOR = 3'h1;
  localparam logic [2:0] RST_REQUEST = 3'h0;
  localparam logic [2:0] RST_CLEAR = 3'h1;
  localparam logic [2:0] RST_INPUT_ONLY = 3'h0;
  // Blink half period of the association indicator, in ms
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);

  // Write request from the command interface
  typedef struct packed {
    logic valid;
    logic [3:0] line;
    logic [2:0] value;
  } iolfs_wr_t;

  // Per-line decoded role
  typedef struct packed {
    logic analog_en;
    logic input_en;
    logic output_en;
    logic output_level;
  } iolfs_role_t;
endpackage : iolfs_pkg

// >>> core/iolfs_blink.sv
// Blink generator for the association indicator
`timescale 1ns/100ps
`default_nettype none
module iolfs_blink #(
  parameter int unsigned HALF_CYC = iolfs_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Control
  input wire logic enable_in,
  output logic blink_out
);
  initial begin
    if (HALF_CYC < 1) $error("HALF_CYC must be at least 1");
  end
  localparam int unsigned CW = $clog2(HALF_CYC + 1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic blink_q, blink_d;

  // Counter runs only while enabled so the indicator starts dark on association
  always_comb begin
    cnt_d = cnt_q;
    blink_d = blink_q;
    if (!enable_in) begin
      cnt_d = '0;
      blink_d = 1'b0;
    end else if (cnt_q == CW'(HALF_CYC - 1)) begin
      cnt_d = '0;
      blink_d = ~blink_q;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cnt_q <= '0;
      blink_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      blink_q <= blink_d;
    end
  end

  assign blink_out = blink_q;
endmodule // iolfs_blink
`default_nettype wire

// >>> core/iolfs_top.sv
// Per-line function selection for nine general-purpose lines
`timescale 1ns/100ps
`default_nettype none
// Operation
// [R1] Lines 0-4 take 0 off, 2 analog, 3 input, 4 drive low, 5 drive high; 1 is refused; reset 0.
// [R2] Line 5 adds 1 as a blinking association indicator, defaulting to 1.
// [R3] Line 6 takes 0 off, 1 request flow control, 3 input, 4 low, 5 high; reset 0.
// [R4] Line 7 takes 0,1 clear flow control,3,4,5,6 and 7 transmit enable low/high; reset 1.
// [R5] Line 8 takes only 0 or 3 and doubles as the sleep pin input; reset 0.
// [R6] A refused or out-of-range value leaves the old setting and function untouched.
module iolfs_top #(
  parameter int unsigned BLINK_HALF_CYC = iolfs_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Setting write port
  input wire iolfs_pkg::iolfs_wr_t wr_in,
  output logic wr_accept_out,
  output logic wr_reject_out,
  // Status and special functions
  input wire logic associated_in,
  input wire logic flow_request_in,
  input wire logic tx_active_in,
  output logic flow_clear_out,
  output logic sleep_request_out,
  // Pins
  input wire logic [8:0] line_pin_in,
  output logic [8:0] line_pin_out,
  output logic [8:0] line_pin_oe_out,
  output logic [8:0] digital_input_role_out,
  output logic [8:0] analog_en_out,
  output logic [8:0] dig_in_out,
  // Setting readback
  output logic [2:0] line_zero_setting_out,
  output logic [2:0] line_one_setting_out,
  output logic [2:0] line_two_setting_out,
  output logic [2:0] line_three_setting_out,
  output logic [2:0] line_four_setting_out,
  output logic [2:0] indicator_line_setting_out,
  output logic [2:0] request_line_setting_out,
  output logic [2:0] clear_line_setting_out,
  output logic [2:0] sleep_input_line_setting_out
);
  initial begin
    if (BLINK_HALF_CYC < 1) $error("BLINK_HALF_CYC must be at least 1");
  end

  // Legal value check per line
  function automatic logic value_ok(input logic [3:0] line, input logic [2:0] v);
    logic ok;
    ok = 1'b0;
    if (line < iolfs_pkg::LINE_INDICATOR) begin
      ok = (v <= iolfs_pkg::SET_OUT_HIGH) && (v != iolfs_pkg::SET_SPECIAL); // [R1]
    end else if (line == iolfs_pkg::LINE_INDICATOR) begin
      ok = (v <= iolfs_pkg::SET_OUT_HIGH); // [R2]
    end else if (line == iolfs_pkg::LINE_REQUEST) begin
      ok = (v <= iolfs_pkg::SET_OUT_HIGH) && (v != iolfs_pkg::SET_ANALOG); // [R3]
    end else if (line == iolfs_pkg::LINE_CLEAR) begin
      ok = (v != iolfs_pkg::SET_ANALOG); // [R4]
    end else if (line == iolfs_pkg::LINE_INPUT_ONLY) begin
      ok = (v == iolfs_pkg::SET_DISABLED) || (v == iolfs_pkg::SET_DIG_IN); // [R5]
    end
    return ok;
  endfunction

  function automatic logic [2:0] reset_value(input int unsigned i);
    logic [2:0] r;
    r = iolfs_pkg::RST_PLAIN;
    if (i == iolfs_pkg::LINE_INDICATOR) r = iolfs_pkg::RST_INDICATOR;
    if (i == iolfs_pkg::LINE_REQUEST) r = iolfs_pkg::RST_REQUEST;
    if (i == iolfs_pkg::LINE_CLEAR) r = iolfs_pkg::RST_CLEAR;
    if (i == iolfs_pkg::LINE_INPUT_ONLY) r = iolfs_pkg::RST_INPUT_ONLY;
    return r;
  endfunction

  logic [2:0] set_q [9];
  logic [2:0] set_d [9];
  logic accept_q, accept_d, reject_q, reject_d;
  logic [8:0] sync1_q, sync2_q;
  logic blink;

  // Settings update only on a legal write
  always_comb begin
    for (int i = 0; i < 9; i++) set_d[i] = set_q[i];
    accept_d = 1'b0;
    reject_d = 1'b0;
    if (wr_in.valid) begin
      if ((wr_in.line < 4'h9) && value_ok(wr_in.line, wr_in.value)) begin
        set_d[wr_in.line] = wr_in.value;
        accept_d = 1'b1;
      end else begin
        reject_d = 1'b1; // [R6]
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < 9; i++) set_q[i] <= reset_value(i); // [R1] [R2] [R3] [R4] [R5]
      accept_q <= 1'b0;
      reject_q <= 1'b0;
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      for (int i = 0; i < 9; i++) set_q[i] <= set_d[i];
      accept_q <= accept_d;
      reject_q <= reject_d;
      sync1_q <= line_pin_in;
      sync2_q <= sync1_q;
    end
  end

  iolfs_blink #(
    .HALF_CYC(BLINK_HALF_CYC)
  ) u_blink (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .enable_in(associated_in && (set_q[5] == iolfs_pkg::SET_SPECIAL)),
    .blink_out(blink)
  );

  // Role decode; special roles take the pin from the generic decode
  always_comb begin
    line_pin_out = '0;
    line_pin_oe_out = '0;
    digital_input_role_out = '0;
    analog_en_out = '0;
    for (int i = 0; i < 9; i++) begin
      case (set_q[i])
        iolfs_pkg::SET_ANALOG: analog_en_out[i] = 1'b1;
        iolfs_pkg::SET_DIG_IN: digital_input_role_out[i] = 1'b1;
        iolfs_pkg::SET_OUT_LOW: line_pin_oe_out[i] = 1'b1;
        iolfs_pkg::SET_OUT_HIGH: begin
          line_pin_oe_out[i] = 1'b1;
          line_pin_out[i] = 1'b1;
        end
        default: ;
      endcase
    end
    if (set_q[5] == iolfs_pkg::SET_SPECIAL) begin
      line_pin_oe_out[5] = 1'b1; // [R2]
      line_pin_out[5] = blink;
    end
    if (set_q[7] == iolfs_pkg::SET_SPECIAL) begin
      line_pin_oe_out[7] = 1'b1; // [R4]
      line_pin_out[7] = flow_clear_out;
    end else if (set_q[7] == iolfs_pkg::SET_TXEN_LOW) begin
      line_pin_oe_out[7] = 1'b1; // [R4]
      line_pin_out[7] = ~tx_active_in;
    end else if (set_q[7] == iolfs_pkg::SET_TXEN_HIGH) begin
      line_pin_oe_out[7] = 1'b1; // [R4]
      line_pin_out[7] = tx_active_in;
    end
  end

  // Request line is an input when used for flow control; low means host may send
  assign flow_clear_out = flow_request_in;
  assign dig_in_out = sync2_q & digital_input_role_out;
  // Sleep pin is read whatever the setting, since it also serves pin sleep
  assign sleep_request_out = sync2_q[8]; // [R5]
  assign wr_accept_out = accept_q;
  assign wr_reject_out = reject_q;
  assign line_zero_setting_out = set_q[0];
  assign line_one_setting_out = set_q[1];
  assign line_two_setting_out = set_q[2];
  assign line_three_setting_out = set_q[3];
  assign line_four_setting_out = set_q[4];
  assign indicator_line_setting_out = set_q[5];
  assign request_line_setting_out = set_q[6];
  assign clear_line_setting_out = set_q[7];
  assign sleep_input_line_setting_out = set_q[8];

  chk_reject_keeps_setting: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R6]
    (wr_in.valid && (wr_in.line == 4'h1) && (wr_in.value == 3'h1))
      |=> (line_one_setting_out == $past(line_one_setting_out)) && wr_reject_out)
    else $error("refused write changed line one");
  chk_line8_legal: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R5]
    (sleep_input_line_setting_out == 3'h0) || (sleep_input_line_setting_out == 3'h3))
    else $error("line eight holds illegal setting");
  chk_line6_no_analog: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R3]
    request_line_setting_out != 3'h2 && !analog_en_out[6])
    else $error("line six in analog role");
  chk_line7_txen: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R4]
    (clear_line_setting_out == 3'h6) |-> line_pin_oe_out[7] && (line_pin_out[7] == !tx_active_in))
    else $error("transmit enable low wrong");
  chk_line0_out_high: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R1]
    (wr_in.valid && wr_in.line == 4'h0 && wr_in.value == 3'h5)
      |=> line_pin_oe_out[0] && line_pin_out[0])
    else $error("line zero not driven high");
  chk_indicator_dark: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R2]
    (!associated_in && indicator_line_setting_out == 3'h1) [*2] |-> !line_pin_out[5])
    else $error("indicator lit while not associated");
  // Further guards on decode and refusal
  chk_reject_holds_all: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R6]
    (wr_in.valid && (wr_in.line > 4'h8)) |=> wr_reject_out && !wr_accept_out
      && $stable(line_zero_setting_out) && $stable(sleep_input_line_setting_out))
    else $error("write to missing line was taken");
  chk_accept_reject_excl: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R6]
    !(wr_accept_out && wr_reject_out))
    else $error("write both taken and refused");
  chk_line0_analog: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R1]
    (wr_in.valid && wr_in.line == 4'h0 && wr_in.value == 3'h2) |=> analog_en_out[0] && !line_pin_oe_out[0])
    else $error("line zero not analog");
  chk_dig_in_gated: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R1]
    (line_zero_setting_out != 3'h3) |-> !dig_in_out[0])
    else $error("line zero input passed while not an input");
  chk_indicator_drive: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R2]
    (indicator_line_setting_out == 3'h1) |-> line_pin_oe_out[5])
    else $error("indicator line not driven");
  chk_line6_request_in: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R3]
    (request_line_setting_out == 3'h1) |-> !line_pin_oe_out[6])
    else $error("request line driven while flow control input");
  chk_line7_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R4]
    (clear_line_setting_out == 3'h1) |-> line_pin_oe_out[7] && (line_pin_out[7] == flow_request_in))
    else $error("clear line does not follow request");
  chk_line7_txen_high: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R4]
    (clear_line_setting_out == 3'h7) |-> line_pin_oe_out[7] && (line_pin_out[7] == tx_active_in))
    else $error("transmit enable high wrong");
  chk_line8_no_drive: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R5]
    !line_pin_oe_out[8] && !analog_en_out[8])
    else $error("input only line driven or analog");
endmodule // iolfs_top
`default_nettype wire

// >>> test/iolfs_host.sv
// Host model that issues setting writes on the command port
`timescale 1ns/100ps
`default_nettype none
module iolfs_host (
  // Clock
  input wire logic ref_clk_in,
  // Write request
  output var iolfs_pkg::iolfs_wr_t wr_out
);
  initial wr_out = '0;
  // Pulse spans one rising edge; idle fields are scrambled so no stale value looks valid
  task automatic write(input logic [3:0] line, input logic [2:0] value);
    @(negedge ref_clk_in);
    wr_out = '{valid: 1'b1, line: line, value: value};
    @(negedge ref_clk_in);
    wr_out = '{valid: 1'b0, line: ~line, value: ~value};
  endtask
endmodule // iolfs_host
`default_nettype wire

// >>> test/tb_top.sv
// Testbench for the line function select
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic ref_clk, rst, assoc, freq, tx, acc, rej, fclr, slp;
  logic [8:0] pin_in, pin_out, oe, role, ana, din;
  logic [2:0] set [9];
  logic [2:0] ms [9];
  logic [7:0] ok [9];
  logic prev;
  iolfs_pkg::iolfs_wr_t wr;
  int err_count, check_count, tg;

  iolfs_host u_host (.ref_clk_in(ref_clk), .wr_out(wr));
  // Short blink period keeps the run brief
  iolfs_top #(.BLINK_HALF_CYC(4)) dut (
    .ref_clk_in(ref_clk), .reset_in(rst), .wr_in(wr), .wr_accept_out(acc),
    .wr_reject_out(rej), .associated_in(assoc), .flow_request_in(freq),
    .tx_active_in(tx), .flow_clear_out(fclr), .sleep_request_out(slp),
    .line_pin_in(pin_in), .line_pin_out(pin_out), .line_pin_oe_out(oe),
    .digital_input_role_out(role), .analog_en_out(ana), .dig_in_out(din),
    .line_zero_setting_out(set[0]), .line_one_setting_out(set[1]),
    .line_two_setting_out(set[2]), .line_three_setting_out(set[3]),
    .line_four_setting_out(set[4]), .indicator_line_setting_out(set[5]),
    .request_line_setting_out(set[6]), .clear_line_setting_out(set[7]),
    .sleep_input_line_setting_out(set[8]));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic put(input logic [3:0] l, input logic [2:0] v, input logic good);
    u_host.write(l, v);
    chk("accept", {8'h0, good}, {8'h0, acc});
    chk("reject", {8'h0, ~good}, {8'h0, rej});
  endtask

  task automatic toggles(input int n);
    tg = 0;
    prev = pin_out[5];
    repeat (n) begin
      @(negedge ref_clk);
      if (pin_out[5] !== prev) tg++;
      prev = pin_out[5];
    end
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    test_done();
  end

  initial begin
    rst = 1'b1; assoc = 1'b0; freq = 1'b0; tx = 1'b1; pin_in = 9'h000;
    // Legal value masks per line, bit n set where value n is allowed
    ok = '{8'h3D, 8'h3D, 8'h3D, 8'h3D, 8'h3D, 8'h3F, 8'h3B, 8'hFB, 8'h09};
    ms = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0, 3'h1, 3'h0};
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    for (int l = 0; l < 9; l++) begin
      chk("reset", {6'h0, ms[l]}, {6'h0, set[l]});
    end
    for (int l = 0; l < 9; l++) begin
      for (int v = 0; v < 8; v++) begin
        put(l[3:0], v[2:0], ok[l][v]);
        if (ok[l][v]) ms[l] = v[2:0];
        chk("setting", {6'h0, ms[l]}, {6'h0, set[l]});
        chk("analog", {8'h0, ms[l] == 3'h2}, {8'h0, ana[l]});
        chk("input", {8'h0, ms[l] == 3'h3}, {8'h0, role[l]});
        if (ms[l] != 3'h1) chk("drive", {7'h0, ms[l] > 3'h3, ms[l] == 3'h5 || ms[l] == 3'h7},
                               {7'h0, oe[l], pin_out[l] & oe[l]});
      end
    end
    put(4'h9, 3'h0, 1'b0);
    put(4'hF, 3'h3, 1'b0);
    put(4'h5, 3'h1, 1'b1);
    assoc = 1'b1;
    toggles(24);
    chk("blink", 9'h1, {8'h0, tg >= 4 && tg <= 7});
    assoc = 1'b0;
    repeat (12) @(negedge ref_clk);
    toggles(12);
    chk("blink idle", 9'h0, tg[8:0]);
    chk("blink dark", 9'h0, {8'h0, pin_out[5]});
    put(4'h7, 3'h1, 1'b1);
    freq = 1'b1;
    @(negedge ref_clk);
    chk("clear", 9'h1, {8'h0, fclr});
    chk("clear pin", 9'h3, {7'h0, oe[7], pin_out[7]});
    freq = 1'b0;
    @(negedge ref_clk);
    chk("clear", 9'h0, {8'h0, fclr});
    put(4'h7, 3'h7, 1'b1);
    tx = 1'b0;
    @(negedge ref_clk);
    chk("tx enable", 9'h2, {7'h0, oe[7], pin_out[7]});
    put(4'h0, 3'h3, 1'b1);
    pin_in = 9'h1FF;
    repeat (3) @(negedge ref_clk);
    chk("dig in", 9'h101, din);
    chk("sleep", 9'h1, {8'h0, slp});
    test_done();
  end
endmodule // tb_top
`default_nettype wire
